/* rtl/apb_reg_port.sv */
`timescale 1ns/100ps
`include "flash_margin_map.svh"

// APB slave with no wait states; read data is caught in the setup cycle.
module apb_reg_port
(
  input  logic                clk_sys,
  input  logic                rstSync,
  input  logic                psel,
  input  logic                penable,
  input  logic                pwrite,
  input  logic [11:0]         paddr,
  input  logic [31:0]         pwdata,
  output logic [31:0]         prdata,
  output logic                pready,
  output logic                pslverr,
  reg_access_if.port          regs
);
  // Maps a byte address onto a register; unaligned is unmapped.
  function automatic flash_margin_pkg::reg_sel_t decode(
    input logic [11:0] addr);
    unique case (addr)
      `FM_OFF_MARGIN:  decode = flash_margin_pkg::SEL_MARGIN;
      `FM_OFF_IRQEN:   decode = flash_margin_pkg::SEL_IRQEN;
      `FM_OFF_KEYSTAT: decode = flash_margin_pkg::SEL_KEYSTAT;
      default:         decode = flash_margin_pkg::SEL_NONE;
    endcase
  endfunction

  assign regs.regSel = decode(paddr);
  assign regs.wrData = pwdata[15:0];
  assign pready      = 1'b1;

  // Writes take effect only at the access edge and only where mapped.
  assign regs.wrStrobe = psel && penable && pwrite &&
                         (regs.regSel != flash_margin_pkg::SEL_NONE);

  // An unmapped address answers with an error in the access phase.
  assign pslverr = psel && penable &&
                   (regs.regSel == flash_margin_pkg::SEL_NONE);

  // Read data is a flop so the bus never sees combinational glitches.
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= {16'h0000, regs.rdData};
  end
endmodule

/* rtl/flash_margin_map.svh */
`ifndef FLASH_MARGIN_MAP_SVH
`define FLASH_MARGIN_MAP_SVH

// Byte addresses of the registers on the peripheral bus.
`define FM_OFF_MARGIN   12'h000
`define FM_OFF_IRQEN    12'h004
`define FM_OFF_KEYSTAT  12'h008

// Password byte values, upper byte of the flash control registers.
`define FM_KEY_READ     8'h96
`define FM_KEY_WRITE    8'hA5

// Field positions.
`define FM_MARGIN_ONE_BIT  5
`define FM_MARGIN_ZERO_BIT 4
`define FM_IRQ_EN_BIT      5
`define FM_KEY_VIOL_BIT    1

// Reset values.
`define FM_MARGIN_RST   1'b0
`define FM_IRQEN_RST    1'b0
`define FM_KEYVIOL_RST  1'b0

`endif

/* rtl/flash_margin_pkg.sv */
package flash_margin_pkg;

  // Register selected by the current bus address.
  typedef enum logic [1:0]
  {
    SEL_MARGIN,
    SEL_IRQEN,
    SEL_KEYSTAT,
    SEL_NONE
  } reg_sel_t;

  // Read mode that the flash array is told to use.
  typedef enum logic [1:0]
  {
    MODE_NORMAL,
    MODE_MARGIN_ZERO,
    MODE_MARGIN_ONE
  } margin_mode_t;

endpackage

/* rtl/flash_margin_read_control.sv */
`timescale 1ns/100ps
`include "flash_margin_map.svh"

// What this block does
// - Bad key sets sticky flag and reset.
// - Margin-one bit selects marginal 1 reads.
// - Margin-zero bit selects marginal 0 reads.
// - Flash execution start clears margin-one bit.
// - Flash execution start clears margin-zero bit.
// - Margin-one wins when both bits set.
// - Enable bit gates access violation interrupt.
// - Other enable bits neither driven nor used.
module flash_margin_read_control
(
  input  logic        clk_sys,
  input  logic        rstn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [11:0] paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        cpuFlashExecStart,
  input  logic        accessViolationFlag,
  output logic        marginOneRead,
  output logic        marginZeroRead,
  output logic        accessViolationIrq,
  output logic        keyViolationFlag,
  output logic        powerUpClearReset
);
  logic                            rstSync;
  logic                            marginOneSel;
  logic                            marginZeroSel;
  logic                            irqEnable;
  logic                            keyOk;
  logic                            ctlWrite;
  logic                            badKeyWrite;
  logic                            next_marginOneSel;
  logic                            next_marginZeroSel;
  flash_margin_pkg::margin_mode_t  mode;
  flash_margin_pkg::margin_mode_t  next_mode;

  reg_access_if bus ();

  reset_sync u_reset_sync
  (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .rstSync (rstSync)
  );

  apb_reg_port u_apb_reg_port
  (
    .clk_sys (clk_sys),
    .rstSync (rstSync),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .regs    (bus)
  );

  // Password check on writes.
  // Both the margin register and the key status register are guarded.
  assign keyOk    = (bus.wrData[15:8] == `FM_KEY_WRITE);
  assign ctlWrite = bus.wrStrobe &&
                    ((bus.regSel == flash_margin_pkg::SEL_MARGIN) ||
                     (bus.regSel == flash_margin_pkg::SEL_KEYSTAT));
  assign badKeyWrite = ctlWrite && !keyOk;

  // Execution clears both bits.
  // The hardware clear wins over a write in the same cycle, so flash
  // code never runs with a marginal read mode left behind.
  always_comb
  begin
    next_marginOneSel  = marginOneSel;
    next_marginZeroSel = marginZeroSel;
    if (cpuFlashExecStart)
    begin
      next_marginOneSel  = 1'b0;
      next_marginZeroSel = 1'b0;
    end
    else if (ctlWrite && keyOk &&
             bus.regSel == flash_margin_pkg::SEL_MARGIN)
    begin
      next_marginOneSel  = bus.wrData[`FM_MARGIN_ONE_BIT];
      next_marginZeroSel = bus.wrData[`FM_MARGIN_ZERO_BIT];
    end
  end

  always_comb
  begin
    if (next_marginOneSel)
      next_mode = flash_margin_pkg::MODE_MARGIN_ONE;
    else if (next_marginZeroSel)
      next_mode = flash_margin_pkg::MODE_MARGIN_ZERO;
    else
      next_mode = flash_margin_pkg::MODE_NORMAL;
  end

  // Margin select bits and the decoded mode are stored together.
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
    begin
      marginOneSel  <= `FM_MARGIN_RST;
      marginZeroSel <= `FM_MARGIN_RST;
      mode          <= flash_margin_pkg::MODE_NORMAL;
    end
    else
    begin
      marginOneSel  <= next_marginOneSel;
      marginZeroSel <= next_marginZeroSel;
      mode          <= next_mode;
    end
  end

  // Mode outputs are straight decodes of the mode flop.
  assign marginOneRead  = (mode == flash_margin_pkg::MODE_MARGIN_ONE);
  assign marginZeroRead = (mode == flash_margin_pkg::MODE_MARGIN_ZERO);

  // Sticky key violation flag.
  // A bad key sets it; a good-key write of zero clears it. The set wins.
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
      keyViolationFlag <= `FM_KEYVIOL_RST;
    else if (badKeyWrite)
      keyViolationFlag <= 1'b1;
    else if (ctlWrite && bus.regSel == flash_margin_pkg::SEL_KEYSTAT &&
             !bus.wrData[`FM_KEY_VIOL_BIT])
      keyViolationFlag <= 1'b0;
  end

  // Reset request pulse.
  // One cycle wide; the system reset logic stretches it as it needs.
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
      powerUpClearReset <= 1'b0;
    else
      powerUpClearReset <= badKeyWrite;
  end

  // Only the flash enable bit is held.
  // The shared register needs no password; other bits are dropped.
  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
      irqEnable <= `FM_IRQEN_RST;
    else if (bus.wrStrobe && bus.regSel == flash_margin_pkg::SEL_IRQEN)
      irqEnable <= bus.wrData[`FM_IRQ_EN_BIT];
  end

  always_ff @(posedge clk_sys or negedge rstSync)
  begin
    if (!rstSync)
      accessViolationIrq <= 1'b0;
    else
      accessViolationIrq <= irqEnable && accessViolationFlag;
  end

  // Read values.
  // Reserved bits are never stored, so they can only read as zero.
  always_comb
  begin
    bus.rdData = 16'h0000;
    unique case (bus.regSel)
      flash_margin_pkg::SEL_MARGIN:
      begin
        bus.rdData[15:8] = `FM_KEY_READ;
        bus.rdData[`FM_MARGIN_ONE_BIT]  = marginOneSel;
        bus.rdData[`FM_MARGIN_ZERO_BIT] = marginZeroSel;
      end
      flash_margin_pkg::SEL_IRQEN:
        bus.rdData[`FM_IRQ_EN_BIT] = irqEnable;
      flash_margin_pkg::SEL_KEYSTAT:
      begin
        bus.rdData[15:8] = `FM_KEY_READ;
        bus.rdData[`FM_KEY_VIOL_BIT] = keyViolationFlag;
      end
      flash_margin_pkg::SEL_NONE:
        bus.rdData = 16'h0000;
    endcase
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstSync);

  // A good-key write to the margin register with no clear racing it.
  sequence goodMarginWrite;
    bus.wrStrobe && bus.regSel == flash_margin_pkg::SEL_MARGIN &&
    bus.wrData[15:8] == 8'hA5 && !cpuFlashExecStart;
  endsequence

  // A write with any other key to a guarded register.
  sequence wrongKeyWrite;
    bus.wrStrobe && bus.regSel != flash_margin_pkg::SEL_IRQEN &&
    bus.wrData[15:8] != 8'hA5;
  endsequence

  chk_key_readback: assert property (
    psel && !penable && !pwrite && paddr == 12'h000
    ##1 psel && penable |-> prdata[15:8] == 8'h96)
    else $error("margin register key byte not 96h");

  chk_bad_key_flag: assert property (
    wrongKeyWrite |=> keyViolationFlag && powerUpClearReset
    ##1 !powerUpClearReset || $past(badKeyWrite))
    else $error("bad key did not set flag and pulse reset");

  chk_flag_sticky: assert property (
    keyViolationFlag && !bus.wrStrobe |=> keyViolationFlag)
    else $error("key violation flag dropped by itself");

  chk_reserved_zero: assert property (
    psel && penable && !pwrite && $past(paddr) == 12'h000 &&
    $past(psel && !penable) |-> prdata[7:6] == 2'b00 &&
    prdata[3:0] == 4'h0 && prdata[31:16] == 16'h0000)
    else $error("reserved margin bits read nonzero");

  chk_margin_one_set: assert property (
    goodMarginWrite ##0 bus.wrData[5] |=> marginOneRead)
    else $error("margin one write not applied");

  chk_margin_zero_set: assert property (
    goodMarginWrite ##0 (bus.wrData[5:4] == 2'b01) |=>
    marginZeroRead && !marginOneRead)
    else $error("margin zero write not applied");

  chk_exec_clear: assert property (
    cpuFlashExecStart |=> !marginOneSel && !marginZeroSel
    && !marginOneRead && !marginZeroRead)
    else $error("flash execution left a margin mode set");

  chk_one_priority: assert property (
    marginOneSel |-> marginOneRead && !marginZeroRead)
    else $error("margin zero active while margin one set");

  chk_irq_gate: assert property (
    !irqEnable [*2] |-> !accessViolationIrq)
    else $error("interrupt raised while disabled");

  chk_irq_follow: assert property (
    irqEnable && accessViolationFlag |=> accessViolationIrq)
    else $error("enabled violation did not raise interrupt");

  chk_shared_bits: assert property (
    bus.regSel == flash_margin_pkg::SEL_IRQEN |->
    bus.rdData[15:6] == 10'h000 && bus.rdData[4:0] == 5'h00)
    else $error("flash block drives a foreign enable bit");

  // Further checks on the key flag, the reset request, the enable and the margin selects.
  // They pin down causes, so a stray reset request, interrupt or key flag clear cannot slip through.
  // A good-key write of zero to the key status register.
  sequence keyFlagClear;
    bus.wrStrobe && bus.regSel == flash_margin_pkg::SEL_KEYSTAT &&
    bus.wrData[15:8] == 8'hA5 && !bus.wrData[1];
  endsequence

  chk_key_no_store: assert property (
    wrongKeyWrite ##0 !cpuFlashExecStart |=>
    marginOneSel == $past(marginOneSel) &&
    marginZeroSel == $past(marginZeroSel))
    else $error("wrong key changed a margin select bit");

  chk_reset_cause: assert property (
    powerUpClearReset |-> $past(badKeyWrite))
    else $error("reset request without a bad key write");

  chk_flag_clear: assert property (
    keyFlagClear |=> !keyViolationFlag)
    else $error("good key write of zero left the flag set");

  chk_flag_hold: assert property (
    keyViolationFlag && !(bus.wrStrobe &&
    bus.regSel == flash_margin_pkg::SEL_KEYSTAT) |=> keyViolationFlag)
    else $error("key violation flag cleared without a status write");

  chk_zero_mode_cause: assert property (
    marginZeroRead |-> marginZeroSel && !marginOneSel)
    else $error("margin zero mode without its select bit alone");

  chk_irq_clear_store: assert property (
    bus.wrStrobe && bus.regSel == flash_margin_pkg::SEL_IRQEN &&
    !bus.wrData[5] |=> !irqEnable)
    else $error("enable clear not stored");

  chk_irq_off_flag: assert property (
    !accessViolationFlag |=> !accessViolationIrq)
    else $error("interrupt raised with no violation flag");

  chk_exec_beats_write: assert property (
    cpuFlashExecStart && bus.wrStrobe &&
    bus.regSel == flash_margin_pkg::SEL_MARGIN |=>
    !marginOneSel && !marginZeroSel)
    else $error("margin write won over flash execution start");
endmodule

/* rtl/reg_access_if.sv */
`timescale 1ns/100ps

// Carries decoded register accesses from the bus port to the core.
interface reg_access_if;
  logic                        wrStrobe;
  flash_margin_pkg::reg_sel_t  regSel;
  logic [15:0]                 wrData;
  logic [15:0]                 rdData;

  modport port
  (
    output wrStrobe,
    output regSel,
    output wrData,
    input  rdData
  );

  modport core
  (
    input  wrStrobe,
    input  regSel,
    input  wrData,
    output rdData
  );
endinterface

/* rtl/reset_sync.sv */
`timescale 1ns/100ps

// Asserts reset at once and releases it two clock edges later.
module reset_sync
(
  input  logic clk_sys,
  input  logic rstn,
  output logic rstSync
);
  logic stage;

  // Only the second flop is seen by the design.
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      stage   <= 1'b0;
      rstSync <= 1'b0;
    end
    else
    begin
      stage   <= 1'b1;
      rstSync <= stage;
    end
  end
endmodule

/* tb/testbench.sv */
`timescale 1ns/100ps
`include "flash_margin_map.svh"

// Drives the block over its register bus and checks the mode outputs.
module testbench;
  logic        clk_sys;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        cpuFlashExecStart;
  logic        accessViolationFlag;
  logic        marginOneRead;
  logic        marginZeroRead;
  logic        accessViolationIrq;
  logic        keyViolationFlag;
  logic        powerUpClearReset;
  logic [31:0] rd;
  logic        err;
  int          err_total;
  int          checked;

  flash_margin_read_control DUT
  (
    .clk_sys             (clk_sys),
    .rstn                (rstn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .cpuFlashExecStart   (cpuFlashExecStart),
    .accessViolationFlag (accessViolationFlag),
    .marginOneRead       (marginOneRead),
    .marginZeroRead      (marginZeroRead),
    .accessViolationIrq  (accessViolationIrq),
    .keyViolationFlag    (keyViolationFlag),
    .powerUpClearReset   (powerUpClearReset)
  );

  // Free running system clock, 20 ns period.
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus transfer; the request holds until pready is seen high.
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_total++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000, rd, err);
    chk(rd, exp);
  endtask

  // Mode outputs are looked at one cycle on, once they have settled.
  task automatic mchk(input logic one, input logic zero);
    @(posedge clk_sys);
    #1;
    chk({30'h0, marginOneRead, marginZeroRead}, {30'h0, one, zero});
  endtask

  initial
  begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cpuFlashExecStart = 1'b0;
    accessViolationFlag = 1'b0;
    err_total = 0;
    checked = 0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(`FM_OFF_MARGIN, 32'h0000_9600);
    rdc(`FM_OFF_IRQEN, 32'h0000_0000);
    wr(`FM_OFF_MARGIN, 32'h0000_A5FF);
    rdc(`FM_OFF_MARGIN, 32'h0000_9630);
    mchk(1'b1, 1'b0);
    wr(`FM_OFF_MARGIN, 32'h0000_A510);
    rdc(`FM_OFF_MARGIN, 32'h0000_9610);
    mchk(1'b0, 1'b1);
    wr(`FM_OFF_MARGIN, 32'h0000_A520);
    mchk(1'b1, 1'b0);
    wr(`FM_OFF_MARGIN, 32'h0000_A500);
    mchk(1'b0, 1'b0);
    wr(`FM_OFF_MARGIN, 32'h0000_A530);
    @(posedge clk_sys);
    cpuFlashExecStart <= 1'b1;
    @(posedge clk_sys);
    cpuFlashExecStart <= 1'b0;
    rdc(`FM_OFF_MARGIN, 32'h0000_9600);
    mchk(1'b0, 1'b0);
    // Execution start during a margin write: the clear wins.
    cpuFlashExecStart <= 1'b1;
    wr(`FM_OFF_MARGIN, 32'h0000_A530);
    cpuFlashExecStart <= 1'b0;
    rdc(`FM_OFF_MARGIN, 32'h0000_9600);
    mchk(1'b0, 1'b0);
    // the flag reaches the request only while enabled.
    @(posedge clk_sys);
    accessViolationFlag <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({31'h0, accessViolationIrq}, 32'h0000_0000);
    wr(`FM_OFF_IRQEN, 32'h0000_00FF);
    @(posedge clk_sys);
    #1;
    chk({31'h0, accessViolationIrq}, 32'h0000_0001);
    rdc(`FM_OFF_IRQEN, 32'h0000_0020);
    // software clears the enable alone, others left set.
    wr(`FM_OFF_IRQEN, 32'h0000_00DF);
    @(posedge clk_sys);
    #1;
    chk({31'h0, accessViolationIrq}, 32'h0000_0000);
    accessViolationFlag <= 1'b0;
    // a wrong key stores nothing, sets the flag, pulses reset.
    wr(`FM_OFF_MARGIN, 32'h0000_A510);
    wr(`FM_OFF_MARGIN, 32'h0000_5A20);
    #1;
    chk({31'h0, powerUpClearReset}, 32'h0000_0001);
    chk({31'h0, keyViolationFlag}, 32'h0000_0001);
    @(posedge clk_sys);
    #1;
    chk({31'h0, powerUpClearReset}, 32'h0000_0000);
    rdc(`FM_OFF_MARGIN, 32'h0000_9610);
    rdc(`FM_OFF_KEYSTAT, 32'h0000_9602);
    wr(`FM_OFF_KEYSTAT, 32'h0000_A500);
    rdc(`FM_OFF_KEYSTAT, 32'h0000_9600);
    // Unmapped word: refused with an error, reads zero.
    xfer(1'b1, 12'h00C, 32'h0000_A5FF, rd, err);
    chk({31'h0, err}, 32'h0000_0001);
    xfer(1'b0, 12'h00C, 32'h0000_0000, rd, err);
    chk({31'h0, err}, 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    rdc(`FM_OFF_MARGIN, 32'h0000_9610);
    // A reset in mid-run returns the registers to their reset values.
    wr(`FM_OFF_IRQEN, 32'h0000_0020);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rdc(`FM_OFF_MARGIN, 32'h0000_9600);
    rdc(`FM_OFF_IRQEN, 32'h0000_0000);
    mchk(1'b0, 1'b0);
    end_sim();
  end
endmodule
